//--- include/draw_cmd_regs.svh
`ifndef DRAW_CMD_REGS_SVH
`define DRAW_CMD_REGS_SVH

// register indexes, byte address is four times the index
`define IDX_X 8'h60
`define IDX_Y 8'h61
`define IDX_DX 8'h62
`define IDX_DY 8'h63
`define IDX_XE 8'h64
`define IDX_YE 8'h65
`define IDX_XS 8'h66
`define IDX_YS 8'h67
`define IDX_PTR_X 8'h68
`define IDX_PTR_Y 8'h69
`define IDX_PATTERN 8'h6a
`define IDX_STATUS 8'h6b
`define IDX_CMD 8'h6e

// command opcodes, high byte of the command word
`define OP_READ_POINTER 8'h02
`define OP_READ_COLOR 8'h9c
`define OP_DOT_DIRECT 8'h08
`define OP_ABS_DOT_MOVE 8'h0c
`define OP_REL_DOT_MOVE 8'h10
`define OP_ABS_LINE_MOVE_V0 8'h14
`define OP_ABS_LINE_MOVE_V1 8'h18
`define OP_ABS_LINE_MOVE_V2 8'h1c
`define OP_ABS_LINE_DIRECT_V0 8'h20
`define OP_ABS_LINE_DIRECT_V1 8'h24
`define OP_ABS_LINE_DIRECT_V2 8'h28

// option byte bit positions
`define FLG_EDGE 6
`define FLG_PAT_INHIBIT 5
`define FLG_EDGE_SELECT 4
`define FLG_PIXEL_ENABLE 3
`define FLG_BITS_PER_PIXEL 2
`define FLG_EDGE_SHIFT 1
`define FLG_END_WRITE 0

// status bit position
`define STATUS_BUSY_BIT 1

// reset values
`define COORD_RST 16'h0000
`define PATTERN_RST 16'hffff
`define BITPTR_RST 4'h0

`endif

//--- include/draw_pkg.sv
package draw_pkg;

  typedef logic [15:0] coord_t;

  // one plotted dot or a colour read address
  typedef struct packed {
    coord_t x;
    coord_t y;
    logic [7:0] flags;
    logic pat;
  } pixel_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DOT,
    S_LINE,
    S_COLRD,
    S_FIN
  } state_t;

endpackage

//--- sim/draw_cmd_dot_line_exec_tb.sv
`timescale 1ns/1ps
`include "draw_cmd_regs.svh"
module draw_cmd_dot_line_exec_tb;
  import draw_pkg::*;
  typedef struct {
    logic [7:0] op, opt;
    logic [15:0] sx, sy;
    int nd;
    logic [15:0] fx, fy, px, py, ex, ey, vx, vy;
  } row_t;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, pix_we, col_rd, col_valid, busy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] col_data;
  wire logic hready;
  pixel_t pix;
  pixel_t dots[$];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  row_t r;
  logic [15:0] ev[8];
  logic [7:0] ri[8] = '{`IDX_PTR_X, `IDX_PTR_Y, `IDX_X, `IDX_Y, `IDX_XS, `IDX_YS, `IDX_XE, `IDX_YE};
  logic [7:0] si[6] = '{`IDX_X, `IDX_Y, `IDX_DX, `IDX_DY, `IDX_XS, `IDX_YS};
  logic [15:0] sv[6] = '{16'ha, 16'h14, 16'h3, 16'h4, 16'h55, 16'h66};
  // direct start matches
  // op, options, x, y, dots, first dot, pointer, x/y after, saved after
  row_t rows[10] = '{
    '{8'h08, 8'h2c, 16'h7, 16'h9, 1, 16'ha, 16'h14, 16'ha, 16'h14, 16'h7, 16'h9, 16'h55, 16'h66},
    '{8'h0c, 8'h08, 16'h7, 16'h9, 1, 16'h7, 16'h9, 16'h7, 16'h9, 16'h7, 16'h9, 16'h55, 16'h66},
    '{8'h10, 8'h08, 16'h7, 16'h9, 1, 16'ha, 16'hd, 16'ha, 16'hd, 16'h7, 16'h9, 16'h55, 16'h66},
    '{8'h14, 8'h01, 16'ha, 16'h14, 5, 16'ha, 16'h14, 16'hd, 16'h18, 16'hd, 16'h18, 16'h55, 16'h66},
    '{8'h18, 8'h00, 16'ha, 16'h14, 4, 16'ha, 16'h14, 16'hd, 16'h18, 16'ha, 16'h14, 16'h55, 16'h66},
    '{8'h1c, 8'h7f, 16'ha, 16'h14, 5, 16'ha, 16'h14, 16'hd, 16'h18, 16'hd, 16'h18, 16'ha, 16'h14},
    '{8'h20, 8'h01, 16'ha, 16'h14, 5, 16'ha, 16'h14, 16'hd, 16'h18, 16'hd, 16'h18, 16'h55, 16'h66},
    '{8'h24, 8'h00, 16'ha, 16'h14, 4, 16'ha, 16'h14, 16'hd, 16'h18, 16'ha, 16'h14, 16'h55, 16'h66},
    '{8'h28, 8'h41, 16'ha, 16'h14, 5, 16'ha, 16'h14, 16'hd, 16'h18, 16'hd, 16'h18, 16'ha, 16'h14},
    '{8'h02, 8'h00, 16'h7, 16'h9, 0, 16'h0, 16'h0, 16'ha, 16'h14, 16'ha, 16'h14, 16'h55, 16'h66}
  };

  // the only slave drives the bus ready
  assign hready = hreadyout;

  draw_cmd_dot_line_exec dut (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pix(pix), .pix_we(pix_we), .col_rd(col_rd), .col_data(col_data),
    .col_valid(col_valid), .busy(busy)
  );

  plane_mem_model mem (
    .sys_clk(sys_clk), .nrst(nrst), .col_rd(col_rd), .pix(pix), .col_valid(col_valid),
    .col_data(col_data)
  );

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // dot logger and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pix_we === 1'b1) dots.push_back(pix);
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] ad(logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction

  task chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // single write: address phase, then data phase
  task wr(logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr <= a;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
  endtask

  // single read, data taken at the completing edge
  task rdr(logic [31:0] a);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr <= a;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task wait_idle();
    @(posedge sys_clk);
    while (busy === 1'b1) @(posedge sys_clk);
  endtask

  task cmd(logic [7:0] op, logic [7:0] opt);
    wr(ad(`IDX_CMD), {16'h0, op, opt});
    wait_idle();
  endtask

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk("busy after reset", busy, 32'h0);
    chk("hresp", hresp, 32'h0);
    rdr(ad(`IDX_X));
    chk("x reset", rd, 32'h0);
    rdr(ad(`IDX_PATTERN));
    chk("pattern reset", rd, 32'hffff);
    // ordinary commands from a known pointer and register set
    wr(ad(`IDX_XE), 32'hd);
    wr(ad(`IDX_YE), 32'h18);
    foreach (rows[k]) begin
      r = rows[k];
      for (int j = 0; j < 6; j++) wr(ad(si[j]), {16'h0, sv[j]});
      cmd(`OP_ABS_DOT_MOVE, 8'h08);
      wr(ad(`IDX_X), {16'h0, r.sx});
      wr(ad(`IDX_Y), {16'h0, r.sy});
      dots.delete();
      cmd(r.op, r.opt);
      chk($sformatf("dot count row %0d", k), dots.size(), r.nd);
      if (r.nd > 0) begin
        chk($sformatf("first dot row %0d", k), {dots[0].x, dots[0].y}, {r.fx, r.fy});
        chk($sformatf("flags row %0d", k), dots[0].flags, r.opt);
      end
      if (r.opt[0] && r.nd > 1) begin
        chk($sformatf("end dot row %0d", k), {dots[r.nd-1].x, dots[r.nd-1].y}, 32'h000d0018);
      end
      ev = '{r.px, r.py, r.ex, r.ey, r.vx, r.vy, 16'hd, 16'h18};
      for (int j = 0; j < 8; j++) begin
        rdr(ad(ri[j]));
        chk($sformatf("reg %0d row %0d", j, k), rd, {16'h0, ev[j]});
      end
    end
    wr(ad(`IDX_PATTERN), 32'h6);
    dots.delete();
    repeat (3) cmd(`OP_DOT_DIRECT, 8'h08);
    chk("pattern bits", {dots[0].pat, dots[1].pat, dots[2].pat}, 32'h3);
    wr(ad(`IDX_X), 32'h1234);
    wr(ad(`IDX_Y), 32'h0a0b);
    cmd(`OP_READ_COLOR, 8'h00);
    rdr(ad(`IDX_DX));
    chk("colour into delta", rd, 32'h0b34);
    // busy during a long line, writes refused meanwhile
    wr(ad(`IDX_X), 32'h0);
    wr(ad(`IDX_Y), 32'h0);
    wr(ad(`IDX_XE), 32'h28);
    wr(ad(`IDX_YE), 32'h0);
    // pointer sits away from x/y here, so the start point tells them apart
    dots.delete();
    wr(ad(`IDX_CMD), {16'h0, `OP_ABS_LINE_MOVE_V1, 8'h01});
    rdr(ad(`IDX_STATUS));
    chk("status busy", rd, 32'h2);
    wr(ad(`IDX_X), 32'h77);
    wait_idle();
    chk("long line dots", dots.size(), 32'd41);
    chk("long line start", {dots[0].x, dots[0].y}, 32'h0);
    rdr(ad(`IDX_STATUS));
    chk("status idle", rd, 32'h0);
    rdr(ad(`IDX_X));
    chk("write while busy", rd, 32'h0);
    wr(ad(`IDX_CMD), 32'hff00);
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk("busy on unknown op", busy, 32'h0);
    // unmapped and write-only places
    wr(32'h400, 32'h5);
    rdr(32'h400);
    chk("unmapped read", rd, 32'h0);
    rdr(ad(`IDX_CMD));
    chk("command reads zero", rd, 32'h0);
    finish_test();
  end
endmodule

//--- sim/plane_mem_model.sv
`timescale 1ns/1ps
module plane_mem_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // plane read request
  input wire logic col_rd,
  input wire draw_pkg::pixel_t pix,
  // plane read answer
  output logic col_valid,
  output logic [15:0] col_data
);
  import draw_pkg::*;
  int cnt;
  logic [15:0] val;
  // answer after a fixed latency, data toggles outside the answer cycle
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      val <= 16'h0;
      col_valid <= 1'b0;
      col_data <= 16'h0;
    end else begin
      col_valid <= 1'b0;
      col_data <= ~col_data;
      if (col_rd) begin
        cnt <= LAT;
        val <= {pix.y[7:0], pix.x[7:0]}; // plane bits derived from the address
      end else if (cnt == 1) begin
        cnt <= 0;
        col_valid <= 1'b1;
        col_data <= val;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

//--- src/draw_cmd_dot_line_exec.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "draw_cmd_regs.svh"
// Operation
// - read pointer command copies drawing pointer into horizontal and vertical registers
// - read colour command gathers one bit per plane into horizontal delta
// - dot direct plots at drawing pointer, pointer stays put
// - every dot advances the pattern bit pointer by one toward msb
// - absolute dot with move plots at coordinates, pointer moves there
// - relative dot with move plots at coordinates plus deltas, pointer moves there
// - absolute line with move draws coordinates to end point, pointer to end
// - line commands carry seven option flags applied to every drawn dot
// - move variant one keeps coordinate, end and saved registers
// - move variant two saves coordinates, loads coordinates from end point
// - direct lines draw from drawing pointer to end point, end dot per flag
// - direct variant zero loads pointer and coordinates from end point
// - direct variant one moves only the drawing pointer to end point
// - direct variant two saves coordinates, loads them from end, moves pointer
// - busy flag high while a command runs, cleared on completion
module draw_cmd_dot_line_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // dot plot port, pix also carries the colour read address
  output draw_pkg::pixel_t pix,
  output logic pix_we,
  // plane read port
  output logic col_rd,
  input wire logic [15:0] col_data,
  input wire logic col_valid,
  // status
  output logic busy
);
  import draw_pkg::*;

  state_t st_ff;
  coord_t x_ff, y_ff, dx_ff, dy_ff, xe_ff, ye_ff, xs_ff, ys_ff, px_ff, py_ff;
  logic [15:0] pat_ff;
  logic [3:0] bitp_ff;
  logic [7:0] op_ff, opt_ff;
  logic wr_pend_ff, rd_pend_ff, ln_start_ff;
  logic [7:0] wr_idx_ff, rd_idx_ff;
  logic acc, amap, wr_go, cmd_wr, plot_now;
  logic [7:0] aidx, new_op;
  coord_t dot_x, dot_y, ln_x0, ln_y0;
  logic pt_valid, pt_last;
  coord_t pt_x, pt_y;

  // address phase decode
  assign acc = hsel && htrans[1] && hready;
  assign aidx = haddr[9:2];
  assign amap = (haddr[31:10] == 22'h000000);
  assign wr_go = wr_pend_ff;
  assign new_op = hwdata[15:8];
  assign cmd_wr = wr_go && (wr_idx_ff == `IDX_CMD) && !busy;

  // dot position per opcode
  // dot placement
  always_comb begin
    dot_x = x_ff + dx_ff;
    dot_y = y_ff + dy_ff;
    if (op_ff == `OP_DOT_DIRECT) begin
      dot_x = px_ff;
      dot_y = py_ff;
    end else if (op_ff == `OP_ABS_DOT_MOVE) begin
      dot_x = x_ff;
      dot_y = y_ff;
    end
  end

  assign ln_x0 = (op_ff >= `OP_ABS_LINE_DIRECT_V0) ? px_ff : x_ff;
  assign ln_y0 = (op_ff >= `OP_ABS_LINE_DIRECT_V0) ? py_ff : y_ff;

  line_stepper #(.W(16)) u_step (
    .clk(sys_clk),
    .nrst(nrst),
    .start(ln_start_ff),
    .x0(ln_x0),
    .y0(ln_y0),
    .x1(xe_ff),
    .y1(ye_ff),
    .pt_valid(pt_valid),
    .pt_x(pt_x),
    .pt_y(pt_y),
    .pt_last(pt_last)
  );

  // end dot only when flag set
  assign plot_now = (st_ff == S_DOT) ||
                    ((st_ff == S_LINE) && pt_valid && !(pt_last && !opt_ff[`FLG_END_WRITE]));

  // bus phases, one wait state on reads
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
      rd_idx_ff <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_ff <= acc && hwrite && amap;
      rd_pend_ff <= acc && !hwrite;
      hreadyout <= !(acc && !hwrite);
      if (acc) begin
        wr_idx_ff <= aidx;
        rd_idx_ff <= amap ? aidx : 8'hff;
      end
    end
  end

  // read data mux, unmapped and write-only read zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_ff) begin
      case (rd_idx_ff)
        `IDX_X: hrdata <= {16'h0000, x_ff};
        `IDX_Y: hrdata <= {16'h0000, y_ff};
        `IDX_DX: hrdata <= {16'h0000, dx_ff};
        `IDX_DY: hrdata <= {16'h0000, dy_ff};
        `IDX_XE: hrdata <= {16'h0000, xe_ff};
        `IDX_YE: hrdata <= {16'h0000, ye_ff};
        `IDX_XS: hrdata <= {16'h0000, xs_ff};
        `IDX_YS: hrdata <= {16'h0000, ys_ff};
        `IDX_PTR_X: hrdata <= {16'h0000, px_ff};
        `IDX_PTR_Y: hrdata <= {16'h0000, py_ff};
        `IDX_PATTERN: hrdata <= {16'h0000, pat_ff};
        `IDX_STATUS: hrdata <= {30'h00000000, busy, 1'b0};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // command sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= S_IDLE;
      op_ff <= 8'h00;
      opt_ff <= 8'h00;
      busy <= 1'b0;
      ln_start_ff <= 1'b0;
      col_rd <= 1'b0;
    end else begin
      ln_start_ff <= 1'b0;
      col_rd <= 1'b0;
      unique case (st_ff)
        S_IDLE: begin
          if (cmd_wr) begin
            op_ff <= new_op;
            opt_ff <= hwdata[7:0];
            busy <= 1'b1;
            case (new_op)
              `OP_READ_POINTER: st_ff <= S_FIN;
              `OP_READ_COLOR: begin
                st_ff <= S_COLRD;
                col_rd <= 1'b1;
              end
              `OP_DOT_DIRECT, `OP_ABS_DOT_MOVE, `OP_REL_DOT_MOVE: st_ff <= S_DOT;
              `OP_ABS_LINE_MOVE_V0, `OP_ABS_LINE_MOVE_V1, `OP_ABS_LINE_MOVE_V2,
              `OP_ABS_LINE_DIRECT_V0, `OP_ABS_LINE_DIRECT_V1, `OP_ABS_LINE_DIRECT_V2: begin
                st_ff <= S_LINE;
                ln_start_ff <= 1'b1;
              end
              default: busy <= 1'b0;
            endcase
          end
        end
        S_DOT: st_ff <= S_FIN;
        S_LINE: begin
          if (pt_valid && pt_last) begin
            st_ff <= S_FIN;
          end
        end
        S_COLRD: begin
          if (col_valid) begin
            st_ff <= S_FIN;
          end
        end
        S_FIN: begin
          busy <= 1'b0;
          st_ff <= S_IDLE;
        end
      endcase
    end
  end

  // plot port, flags ride with every dot
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pix <= '0;
      pix_we <= 1'b0;
    end else begin
      pix_we <= plot_now;
      pix.flags <= opt_ff;
      pix.pat <= pat_ff[bitp_ff];
      if (st_ff == S_DOT) begin
        pix.x <= dot_x;
        pix.y <= dot_y;
      end else if (st_ff == S_LINE) begin
        pix.x <= pt_x;
        pix.y <= pt_y;
      end else if (cmd_wr && (new_op == `OP_READ_COLOR)) begin
        pix.x <= x_ff;
        pix.y <= y_ff;
      end
    end
  end

  // pattern register and its bit pointer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pat_ff <= `PATTERN_RST;
      bitp_ff <= `BITPTR_RST;
    end else if (wr_go && !busy && (wr_idx_ff == `IDX_PATTERN)) begin
      pat_ff <= hwdata[15:0];
      bitp_ff <= `BITPTR_RST;
    end else if (plot_now || ((st_ff == S_LINE) && pt_valid)) begin
      bitp_ff <= bitp_ff + 4'h1;
    end
  end

  // coordinate registers, bus writes and command results
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      x_ff <= `COORD_RST;
      y_ff <= `COORD_RST;
      dx_ff <= `COORD_RST;
      dy_ff <= `COORD_RST;
      xe_ff <= `COORD_RST;
      ye_ff <= `COORD_RST;
      xs_ff <= `COORD_RST;
      ys_ff <= `COORD_RST;
      px_ff <= `COORD_RST;
      py_ff <= `COORD_RST;
    end else if (wr_go && !busy) begin
      case (wr_idx_ff)
        `IDX_X: x_ff <= hwdata[15:0];
        `IDX_Y: y_ff <= hwdata[15:0];
        `IDX_DX: dx_ff <= hwdata[15:0];
        `IDX_DY: dy_ff <= hwdata[15:0];
        `IDX_XE: xe_ff <= hwdata[15:0];
        `IDX_YE: ye_ff <= hwdata[15:0];
        `IDX_XS: xs_ff <= hwdata[15:0];
        `IDX_YS: ys_ff <= hwdata[15:0];
        default: ;
      endcase
    end else if ((st_ff == S_COLRD) && col_valid) begin
      dx_ff <= col_data;
    end else if (st_ff == S_FIN) begin
      case (op_ff)
        `OP_READ_POINTER: begin
          x_ff <= px_ff;
          y_ff <= py_ff;
        end
        `OP_ABS_DOT_MOVE, `OP_REL_DOT_MOVE: begin
          px_ff <= dot_x;
          py_ff <= dot_y;
        end
        `OP_ABS_LINE_MOVE_V0, `OP_ABS_LINE_DIRECT_V0: begin
          px_ff <= xe_ff;
          py_ff <= ye_ff;
          x_ff <= xe_ff;
          y_ff <= ye_ff;
        end
        `OP_ABS_LINE_MOVE_V1, `OP_ABS_LINE_DIRECT_V1: begin
          px_ff <= xe_ff;
          py_ff <= ye_ff;
        end
        `OP_ABS_LINE_MOVE_V2, `OP_ABS_LINE_DIRECT_V2: begin
          xs_ff <= x_ff;
          ys_ff <= y_ff;
          x_ff <= xe_ff;
          y_ff <= ye_ff;
          px_ff <= xe_ff;
          py_ff <= ye_ff;
        end
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence dot_issue_s;
    (st_ff == S_DOT) ##1 (st_ff == S_FIN);
  endsequence

  sequence line_tail_s;
    (st_ff == S_LINE) && pt_valid && pt_last;
  endsequence

  busy_start_a: assert property (cmd_wr && (new_op == `OP_DOT_DIRECT) |=> busy ##1 busy)
    else $error("busy not raised on dot start");
  dot_busy_clear_a: assert property (dot_issue_s |=> !busy && (st_ff == S_IDLE))
    else $error("busy not cleared after dot");
  dot_direct_pos_a: assert property ((st_ff == S_DOT) && (op_ff == `OP_DOT_DIRECT)
    |=> pix_we && (pix.x == $past(px_ff)) ##1 (px_ff == $past(px_ff, 2)))
    else $error("dot direct misplaced or pointer moved");
  bit_pointer_step_a: assert property ((st_ff == S_DOT) |=> (bitp_ff == $past(bitp_ff) + 4'h1))
    else $error("pattern pointer did not step");
  abs_dot_move_a: assert property ((st_ff == S_DOT) && (op_ff == `OP_ABS_DOT_MOVE)
    |=> (pix.x == $past(x_ff)) ##1 (px_ff == pix.x) && (py_ff == pix.y))
    else $error("absolute dot move wrong");
  rel_dot_move_a: assert property ((st_ff == S_DOT) && (op_ff == `OP_REL_DOT_MOVE)
    |=> (pix.x == 16'($past(x_ff) + $past(dx_ff))) ##1 (px_ff == pix.x))
    else $error("relative dot move wrong");
  read_ptr_copy_a: assert property ((st_ff == S_FIN) && (op_ff == `OP_READ_POINTER)
    |=> (x_ff == $past(px_ff)) && (y_ff == $past(py_ff)))
    else $error("pointer not copied out");
  read_col_load_a: assert property ((st_ff == S_COLRD) && col_valid |=> (dx_ff == $past(col_data)))
    else $error("colour bits not loaded");
  line_end_dot_a: assert property (line_tail_s |=> (pix_we == $past(opt_ff[`FLG_END_WRITE]))
    && (pix.x == $past(pt_x)))
    else $error("end dot not per flag");
  move_v1_keep_a: assert property ((st_ff == S_FIN) && (op_ff == `OP_ABS_LINE_MOVE_V1)
    |=> $stable(x_ff) && $stable(xs_ff) && $stable(xe_ff) && (px_ff == xe_ff))
    else $error("move variant one changed registers");
  save_load_a: assert property ((st_ff == S_FIN) && ((op_ff == `OP_ABS_LINE_MOVE_V2) ||
    (op_ff == `OP_ABS_LINE_DIRECT_V2)) |=> (xs_ff == $past(x_ff)) && (x_ff == xe_ff) && (px_ff == xe_ff))
    else $error("variant two save or load wrong");
  direct_v0_a: assert property ((st_ff == S_FIN) && (op_ff == `OP_ABS_LINE_DIRECT_V0)
    |=> (px_ff == xe_ff) && (y_ff == ye_ff) && $stable(ys_ff))
    else $error("direct variant zero wrong");
  direct_v1_a: assert property ((st_ff == S_FIN) && (op_ff == `OP_ABS_LINE_DIRECT_V1)
    |=> $stable(x_ff) && $stable(y_ff) && (py_ff == ye_ff))
    else $error("direct variant one wrong");
endmodule

//--- src/line_stepper.sv
`timescale 1ns/1ps
module line_stepper #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // line request
  input wire logic start,
  input wire logic [W-1:0] x0,
  input wire logic [W-1:0] y0,
  input wire logic [W-1:0] x1,
  input wire logic [W-1:0] y1,
  // one point per cycle
  output logic pt_valid,
  output logic [W-1:0] pt_x,
  output logic [W-1:0] pt_y,
  output logic pt_last
);
  localparam int E = W + 3;
  logic signed [E-1:0] ddx, ddy, adx, ady, e2, err_n;
  logic signed [E-1:0] err_ff, dx_ff, dy_ff;
  logic [W-1:0] cx_ff, cy_ff, ex_ff, ey_ff;
  logic sx_ff, sy_ff, run_ff, at_end;

  // signed spans of the line
  assign ddx = $signed({3'b000, x1}) - $signed({3'b000, x0});
  assign ddy = $signed({3'b000, y1}) - $signed({3'b000, y0});
  assign adx = ddx[E-1] ? -ddx : ddx;
  assign ady = ddy[E-1] ? -ddy : ddy;
  assign e2 = {err_ff[E-2:0], 1'b0};
  assign at_end = (cx_ff == ex_ff) && (cy_ff == ey_ff);

  // error term after one step
  always_comb begin
    err_n = err_ff;
    if (e2 >= dy_ff) begin
      err_n = err_n + dy_ff;
    end
    if (e2 <= dx_ff) begin
      err_n = err_n + dx_ff;
    end
  end

  // bresenham walk, end point always emitted last
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 1'b0;
      pt_valid <= 1'b0;
      pt_last <= 1'b0;
      pt_x <= '0;
      pt_y <= '0;
      cx_ff <= '0;
      cy_ff <= '0;
      ex_ff <= '0;
      ey_ff <= '0;
      sx_ff <= 1'b0;
      sy_ff <= 1'b0;
      err_ff <= '0;
      dx_ff <= '0;
      dy_ff <= '0;
    end else if (start) begin
      run_ff <= 1'b1;
      pt_valid <= 1'b0;
      pt_last <= 1'b0;
      cx_ff <= x0;
      cy_ff <= y0;
      ex_ff <= x1;
      ey_ff <= y1;
      sx_ff <= ddx[E-1];
      sy_ff <= ddy[E-1];
      dx_ff <= adx;
      dy_ff <= -ady;
      err_ff <= adx - ady;
    end else if (run_ff) begin
      pt_valid <= 1'b1;
      pt_x <= cx_ff;
      pt_y <= cy_ff;
      pt_last <= at_end;
      if (at_end) begin
        run_ff <= 1'b0;
      end else begin
        err_ff <= err_n;
        if (e2 >= dy_ff) begin
          cx_ff <= sx_ff ? cx_ff - 1'b1 : cx_ff + 1'b1;
        end
        if (e2 <= dx_ff) begin
          cy_ff <= sy_ff ? cy_ff - 1'b1 : cy_ff + 1'b1;
        end
      end
    end else begin
      pt_valid <= 1'b0;
      pt_last <= 1'b0;
    end
  end
endmodule
